// ### rxvsm_port_regs.sv
`timescale 1ns/1ps
module rxvsm_port_regs
    import rxvsm_pkg::*;
#(
    parameter logic [1:0]  PORT_ID      = 2'h0,
    parameter int unsigned SETTLE_CYC_0 = SETTLE_T0_NS / CLK_PERIOD_NS,
    parameter int unsigned SETTLE_CYC_1 = SETTLE_T1_NS / CLK_PERIOD_NS,
    parameter int unsigned SETTLE_CYC_2 = SETTLE_T2_NS / CLK_PERIOD_NS,
    parameter int unsigned SETTLE_CYC_3 = SETTLE_T3_NS / CLK_PERIOD_NS
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // register access from the serial control port
    input  wire logic [1:0]        port_select,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata_q,
    output logic                   reg_rvalid_q,
    // interrupt enables held in the port interrupt enable register
    input  wire logic              irq_en_frame_lines_change,
    input  wire logic              irq_en_line_length_change,
    // received video timing
    input  wire logic              vid_frame_valid,
    input  wire logic              vid_line_valid,
    // input clock frequency measurement
    input  wire logic              freq_meas_valid,
    input  wire logic [FREQ_W-1:0] freq_meas_mhz,
    // monitor status
    output logic                   serial_clock_absent_q,
    output logic                   freq_stable_q,
    output logic [FREQ_W-1:0]      freq_value_mhz_q
);

    // register file state
    logic [7:0]              freq_ctl_q;
    logic [7:0]              scratch_q;

    // video measurement state
    logic                    frame_valid_prev_q;
    logic                    line_valid_prev_q;
    logic [MEAS_W-1:0]       lines_cnt_q;
    logic [MEAS_W-1:0]       len_cnt_q;
    logic [MEAS_W-1:0]       last_len_q;

    // frequency detector state
    rxvsm_fd_state_type      fd_state_q;
    logic [SETTLE_CNT_W-1:0] settle_cnt_q;

    // decoded strobes and combinational helpers
    logic                    port_hit;
    logic                    wr_hit;
    logic                    rd_hit;
    logic                    frame_end;
    logic                    frame_start;
    logic                    line_end;
    logic [MEAS_W-1:0]       lines_final;
    logic [MEAS_W-1:0]       len_final;
    logic [7:0]              lines_hi;
    logic [7:0]              lines_lo;
    logic [7:0]              len_hi;
    logic [7:0]              len_lo;
    logic [1:0]              margin;
    logic [1:0]              settle_sel;
    logic [3:0]              floor_mhz;
    logic [FREQ_W-1:0]       freq_diff;
    logic                    beyond_margin;
    logic [SETTLE_CNT_W-1:0] settle_lim;
    logic [7:0]              rd_mux;

    // accesses reach this port only when the host selected it
    assign port_hit = (port_select == PORT_ID);
    assign wr_hit   = reg_wr && port_hit;
    assign rd_hit   = reg_rd && port_hit;

    // control fields
    assign margin     = freq_ctl_q[MARGIN_MSB:MARGIN_LSB];
    assign settle_sel = freq_ctl_q[SETTLE_MSB:SETTLE_LSB];
    assign floor_mhz  = freq_ctl_q[FLOOR_MSB:FLOOR_LSB];

    // writable registers; read-only offsets ignore writes
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            freq_ctl_q <= CLOCK_FREQ_MON_CTL_RST;
            scratch_q  <= MESSAGE_SCRATCH_0_RST;
        end
        else if (wr_hit)
        begin
            if (reg_addr == ADDR_CLOCK_FREQ_MON_CTL)
                freq_ctl_q <= reg_wdata;
            else if (reg_addr == ADDR_MESSAGE_SCRATCH_0)
                scratch_q <= reg_wdata;
        end
    end

    // edges of the video timing levels
    assign frame_end   = frame_valid_prev_q && !vid_frame_valid;
    assign frame_start = !frame_valid_prev_q && vid_frame_valid;
    assign line_end    = line_valid_prev_q && !vid_line_valid;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            frame_valid_prev_q <= 1'b0;
            line_valid_prev_q  <= 1'b0;
        end
        else
        begin
            frame_valid_prev_q <= vid_frame_valid;
            line_valid_prev_q  <= vid_line_valid;
        end
    end

    // a line ending in the frame end cycle still belongs to that frame
    assign lines_final = lines_cnt_q + MEAS_W'(line_end);
    assign len_final   = line_end ? len_cnt_q : last_len_q;

    // lines per frame; wraps rather than saturates, as 16 bits is ample
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            lines_cnt_q <= '0;
        else if (frame_start)
            lines_cnt_q <= '0;
        else if (line_end && vid_frame_valid)
            lines_cnt_q <= lines_cnt_q + MEAS_W'(1);
    end

    // cycles per line, and the length of the line that just ended
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            len_cnt_q  <= '0;
            last_len_q <= '0;
        end
        else
        begin
            if (vid_line_valid)
                len_cnt_q <= line_valid_prev_q ?
                             len_cnt_q + MEAS_W'(1) : MEAS_W'(1);
            if (line_end)
                last_len_q <= len_cnt_q;
        end
    end

    // reported line count with freeze and byte latching
    rxvsm_meas_report #(
        .W         (MEAS_W)
    ) u_lines_report (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .capture   (frame_end),
        .value     (lines_final),
        .freeze_en (irq_en_frame_lines_change),
        .rd_hi     (rd_hit && reg_addr == ADDR_FRAME_LINES_HIGH),
        .rd_lo     (rd_hit && reg_addr == ADDR_FRAME_LINES_LOW),
        .hi_byte   (lines_hi),
        .lo_byte   (lines_lo)
    );

    // reported line length with freeze and byte latching
    rxvsm_meas_report #(
        .W         (MEAS_W)
    ) u_len_report (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .capture   (frame_end),
        .value     (len_final),
        .freeze_en (irq_en_line_length_change),
        .rd_hi     (rd_hit && reg_addr == ADDR_LINE_LENGTH_HIGH),
        .rd_lo     (rd_hit && reg_addr == ADDR_LINE_LENGTH_LOW),
        .hi_byte   (len_hi),
        .lo_byte   (len_lo)
    );

    // read data select; unmapped offsets read as zero
    always_comb
    begin
        if (reg_addr == ADDR_FRAME_LINES_HIGH)
            rd_mux = lines_hi;
        else if (reg_addr == ADDR_FRAME_LINES_LOW)
            rd_mux = lines_lo;
        else if (reg_addr == ADDR_LINE_LENGTH_HIGH)
            rd_mux = len_hi;
        else if (reg_addr == ADDR_LINE_LENGTH_LOW)
            rd_mux = len_lo;
        else if (reg_addr == ADDR_CLOCK_FREQ_MON_CTL)
            rd_mux = freq_ctl_q;
        else if (reg_addr == ADDR_MESSAGE_SCRATCH_0)
            rd_mux = scratch_q;
        else
            rd_mux = READ_ZERO;
    end

    // read answer one cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            reg_rdata_q  <= READ_ZERO;
            reg_rvalid_q <= 1'b0;
        end
        else
        begin
            reg_rvalid_q <= rd_hit;
            if (rd_hit)
                reg_rdata_q <= rd_mux;
        end
    end

    // distance between a new measurement and the stored one
    assign freq_diff = (freq_meas_mhz >= freq_value_mhz_q) ?
                       freq_meas_mhz - freq_value_mhz_q :
                       freq_value_mhz_q - freq_meas_mhz;
    assign beyond_margin = freq_diff > {6'h00, margin};

    // settle time in cycles for the selected code
    always_comb
    begin
        case (settle_sel)
            SETTLE_SEL_40US:  settle_lim = SETTLE_CNT_W'(SETTLE_CYC_0);
            SETTLE_SEL_80US:  settle_lim = SETTLE_CNT_W'(SETTLE_CYC_1);
            SETTLE_SEL_320US: settle_lim = SETTLE_CNT_W'(SETTLE_CYC_2);
            default:          settle_lim = SETTLE_CNT_W'(SETTLE_CYC_3);
        endcase
    end

    // detector: the first sample is always taken, later ones only when
    // they leave the margin band, which restarts the settle count
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            fd_state_q       <= FD_IDLE;
            settle_cnt_q     <= '0;
            freq_value_mhz_q <= '0;
        end
        else
        begin
            case (fd_state_q)
                FD_IDLE:
                begin
                    if (freq_meas_valid)
                    begin
                        freq_value_mhz_q <= freq_meas_mhz;
                        settle_cnt_q     <= '0;
                        fd_state_q       <= FD_SETTLING;
                    end
                end
                FD_SETTLING:
                begin
                    if (freq_meas_valid && beyond_margin)
                    begin
                        freq_value_mhz_q <= freq_meas_mhz;
                        settle_cnt_q     <= '0;
                    end
                    else if (settle_cnt_q + SETTLE_CNT_W'(1)
                             >= settle_lim)
                        fd_state_q <= FD_STABLE;
                    else
                        settle_cnt_q <= settle_cnt_q + SETTLE_CNT_W'(1);
                end
                FD_STABLE:
                begin
                    if (freq_meas_valid && beyond_margin)
                    begin
                        freq_value_mhz_q <= freq_meas_mhz;
                        settle_cnt_q     <= '0;
                        fd_state_q       <= FD_SETTLING;
                    end
                end
                default:
                    fd_state_q <= FD_IDLE;
            endcase
        end
    end

    // status flags; absent while idle or while the stored clock is below the floor
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            serial_clock_absent_q <= 1'b1;
            freq_stable_q         <= 1'b0;
        end
        else
        begin
            serial_clock_absent_q <=
                (fd_state_q == FD_IDLE) ||
                (freq_value_mhz_q < {4'h0, floor_mhz});
            freq_stable_q <= (fd_state_q == FD_STABLE);
        end
    end

    // checks, all in the single register clock domain

    sequence s_scratch_write;
        wr_hit && reg_addr == ADDR_MESSAGE_SCRATCH_0;
    endsequence

    sequence s_low_sample_stored;
        freq_meas_valid && (fd_state_q == FD_IDLE || beyond_margin) &&
        freq_meas_mhz < {4'h0, floor_mhz};
    endsequence

    AST_READ_ANSWER: assert property (
        @(posedge clk) disable iff (sys_rst)
        reg_rd |=> reg_rvalid_q == $past(port_hit))
        else $error("read answer missing or given for another port");

    AST_CTL_RESET_VALUE: assert property (
        @(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> freq_ctl_q == CLOCK_FREQ_MON_CTL_RST)
        else $error("monitor control has wrong reset value");

    AST_SCRATCH_READBACK: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_scratch_write ##1 !wr_hit ##1 (!wr_hit && rd_hit &&
            reg_addr == ADDR_MESSAGE_SCRATCH_0)
            |=> reg_rdata_q == $past(reg_wdata, 3))
        else $error("mailbox did not return written byte");

    AST_MARGIN_HOLD: assert property (
        @(posedge clk) disable iff (sys_rst)
        (freq_meas_valid && fd_state_q != FD_IDLE && !beyond_margin)
            |=> $stable(freq_value_mhz_q))
        else $error("frequency updated inside the margin band");

    AST_MARGIN_TAKE: assert property (
        @(posedge clk) disable iff (sys_rst)
        (freq_meas_valid && beyond_margin)
            |=> freq_value_mhz_q == $past(freq_meas_mhz))
        else $error("frequency outside margin not stored");

    AST_SETTLE_EARLY: assert property (
        @(posedge clk) disable iff (sys_rst)
        (fd_state_q == FD_SETTLING &&
         settle_cnt_q + SETTLE_CNT_W'(1) < settle_lim)
            |=> fd_state_q != FD_STABLE)
        else $error("clock declared stable before settle time");

    AST_ABSENT_FLAG: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_low_sample_stored |=> ##1 serial_clock_absent_q)
        else $error("clock below floor not flagged absent");

    AST_LAST_LINE_LENGTH: assert property (
        @(posedge clk) disable iff (sys_rst)
        line_end |=> last_len_q == $past(len_cnt_q))
        else $error("line length not taken from the last line");

endmodule

// ### rxvsm_pkg.sv
// shared constants for the per-port video statistics and clock monitor
package rxvsm_pkg;

    // register offsets inside the per-port page
    localparam logic [7:0] ADDR_FRAME_LINES_HIGH   = 8'h73;
    localparam logic [7:0] ADDR_FRAME_LINES_LOW    = 8'h74;
    localparam logic [7:0] ADDR_LINE_LENGTH_HIGH   = 8'h75;
    localparam logic [7:0] ADDR_LINE_LENGTH_LOW    = 8'h76;
    localparam logic [7:0] ADDR_CLOCK_FREQ_MON_CTL = 8'h77;
    localparam logic [7:0] ADDR_MESSAGE_SCRATCH_0  = 8'h78;

    // reset values
    localparam logic [7:0] CLOCK_FREQ_MON_CTL_RST  = 8'hc5;
    localparam logic [7:0] MESSAGE_SCRATCH_0_RST   = 8'h00;
    localparam logic [7:0] READ_ZERO               = 8'h00;

    // field layout of the clock frequency monitor control register
    localparam int MARGIN_MSB = 7;
    localparam int MARGIN_LSB = 6;
    localparam int SETTLE_MSB = 5;
    localparam int SETTLE_LSB = 4;
    localparam int FLOOR_MSB  = 3;
    localparam int FLOOR_LSB  = 0;

    // settle time select codes
    localparam logic [1:0] SETTLE_SEL_40US   = 2'h0;
    localparam logic [1:0] SETTLE_SEL_80US   = 2'h1;
    localparam logic [1:0] SETTLE_SEL_320US  = 2'h2;

    // timing: clock period and settle times in ns, and the settle counter width
    localparam int CLK_PERIOD_NS  = 20;
    localparam int SETTLE_T0_NS   = 40000;
    localparam int SETTLE_T1_NS   = 80000;
    localparam int SETTLE_T2_NS   = 320000;
    localparam int SETTLE_T3_NS   = 1280000;
    localparam int SETTLE_CNT_W   = 17;

    // measurement widths
    localparam int MEAS_W = 16;
    localparam int FREQ_W = 8;

    // frequency detector state
    typedef enum logic [1:0] {
        FD_IDLE,
        FD_SETTLING,
        FD_STABLE
    } rxvsm_fd_state_type;

endpackage

// ### rxvsm_meas_report.sv
`timescale 1ns/1ps
// one 16-bit reported measurement: freeze-until-read and high/low latching
module rxvsm_meas_report
    import rxvsm_pkg::*;
#(
    parameter int W = MEAS_W
)
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // capture side
    input  wire logic         capture,
    input  wire logic [W-1:0] value,
    input  wire logic         freeze_en,
    // read strobes
    input  wire logic         rd_hi,
    input  wire logic         rd_lo,
    // reported bytes
    output logic [7:0]        hi_byte,
    output logic [7:0]        lo_byte
);

    logic [W-1:0] value_q;
    logic         held_q;
    logic [7:0]   lo_shadow_q;
    logic         lo_latched_q;
    logic         take;

    // a pending unread update blocks new captures while freezing is on
    assign take = capture && !(freeze_en && held_q);

    // reported value
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            value_q <= '0;
        else if (take)
            value_q <= value;
    end

    // unread marker; a capture in the read cycle wins over the clear
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            held_q <= 1'b0;
        else if (take)
            held_q <= 1'b1;
        else if (rd_hi || rd_lo)
            held_q <= 1'b0;
    end

    // low byte snapshot taken at the high byte read
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            lo_shadow_q  <= 8'h00;
            lo_latched_q <= 1'b0;
        end
        else if (rd_hi)
        begin
            lo_shadow_q  <= value_q[7:0];
            lo_latched_q <= 1'b1;
        end
        else if (rd_lo)
            lo_latched_q <= 1'b0;
    end

    assign hi_byte = value_q[W-1:W-8];
    assign lo_byte = lo_latched_q ? lo_shadow_q : value_q[7:0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_hi_read;
        rd_hi;
    endsequence

    sequence s_quiet3;
        (!rd_hi && !rd_lo) [*3];
    endsequence

    AST_CAPTURE_TAKES: assert property (
        (capture && !held_q) |=> value_q == $past(value))
        else $error("measurement not captured at end of frame");

    AST_FREEZE_HOLDS: assert property (
        (freeze_en && held_q && !rd_hi && !rd_lo)
            |=> $stable(value_q))
        else $error("frozen measurement changed before read");

    AST_LOW_CONSISTENT: assert property (
        s_hi_read ##1 s_quiet3 |-> lo_byte == $past(value_q[7:0], 3))
        else $error("low byte not consistent with high byte read");

endmodule

// ### rxvsm_host_model.sv
`timescale 1ns/1ps
// register host: one strobe pulse per access, idle lines carry junk
module rxvsm_host_model
(
    // clock
    input  wire logic       clk,
    // register bus toward the port registers
    output logic [1:0]      port_select,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata_q,
    input  wire logic       reg_rvalid_q
);
    // quiet bus at time zero
    initial
    begin
        port_select = 2'h0;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
    end

    // the page choice must land before any access it steers
    task automatic sel(input logic [1:0] p);
        @(posedge clk);
        port_select <= p;
    endtask

    // write: one strobe cycle, then inverted lines so stale data never helps
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    // read: answer expected one cycle after the taken edge, bounded wait
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
        int n;
        d  = 8'h00;
        ok = 1'b0;
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        for (n = 0; n < 4 && ok !== 1'b1; n++)
        begin
            @(posedge clk);
            if (reg_rvalid_q === 1'b1)
            begin
                ok = 1'b1;
                d  = reg_rdata_q;
            end
        end
    endtask
endmodule

// ### test_rx_port_video_stats_freq_monitor.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("wrong value %s exp %0h got %0h", nm, exp, got); \
        end \
    end

module test_rx_port_video_stats_freq_monitor
    import rxvsm_pkg::*;
;
    // stimulus and observed signals
    logic       clk = 1'b0;
    logic       sys_rst;
    logic [1:0] port_select;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata_q;
    logic       reg_rvalid_q;
    logic       ie_lines;
    logic       ie_len;
    logic       frame_valid;
    logic       line_valid;
    logic       fm_valid;
    logic [7:0] fm_mhz;
    logic       serial_clock_absent_q;
    logic       freq_stable_q;
    logic [7:0] freq_value_mhz_q;
    int         err_total = 0;
    int         samples_checked = 0;

    always #10 clk = ~clk;

    // settle counts kept short but in the documented 1:2:8:32 ratio
    rxvsm_port_regs #(.SETTLE_CYC_0(20), .SETTLE_CYC_1(40),
        .SETTLE_CYC_2(160), .SETTLE_CYC_3(640)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .port_select(port_select),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q),
        .irq_en_frame_lines_change(ie_lines),
        .irq_en_line_length_change(ie_len),
        .vid_frame_valid(frame_valid), .vid_line_valid(line_valid),
        .freq_meas_valid(fm_valid), .freq_meas_mhz(fm_mhz),
        .serial_clock_absent_q(serial_clock_absent_q),
        .freq_stable_q(freq_stable_q),
        .freq_value_mhz_q(freq_value_mhz_q));

    rxvsm_host_model host_u (
        .clk(clk), .port_select(port_select), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));

    // closing report, the only place the run ends
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // read and compare; a missing answer aborts the run
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp,
                         input string nm);
        logic [7:0] d;
        logic       ok;
        host_u.rd(a, d, ok);
        `CHK(nm, 1'b1, ok)
        if (ok !== 1'b1)
            end_sim();
        `CHK(nm, exp, d)
    endtask

    // one frame: lines of len cycles, the final line last cycles long
    task automatic frame(input int lines, input int len, input int last);
        int i;
        @(posedge clk);
        frame_valid <= 1'b1;
        for (i = 0; i < lines; i++)
        begin
            @(posedge clk);
            line_valid <= 1'b1;
            repeat ((i == lines - 1) ? last : len) @(posedge clk);
            line_valid <= 1'b0;
        end
        @(posedge clk);
        frame_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // one frequency sample, then time for value and floor flag to settle
    task automatic meas(input logic [7:0] v);
        @(posedge clk);
        fm_valid <= 1'b1;
        fm_mhz   <= v;
        @(posedge clk);
        fm_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset();
        `CHK("absent rst", 1'b1, serial_clock_absent_q)
        `CHK("stable rst", 1'b0, freq_stable_q)
        rdchk(ADDR_FRAME_LINES_HIGH, 8'h00, "lines hi rst");
        rdchk(ADDR_FRAME_LINES_LOW, 8'h00, "lines lo rst");
        rdchk(ADDR_LINE_LENGTH_HIGH, 8'h00, "len hi rst");
        rdchk(ADDR_LINE_LENGTH_LOW, 8'h00, "len lo rst");
        rdchk(ADDR_CLOCK_FREQ_MON_CTL, 8'hc5, "ctl rst");
        rdchk(ADDR_MESSAGE_SCRATCH_0, 8'h00, "mbox rst");
        rdchk(8'h80, 8'h00, "unmapped");
    endtask

    // mailbox, read-only place, and a different port selected
    task automatic t_mailbox();
        logic [7:0] d;
        logic       ok;
        host_u.wr(ADDR_MESSAGE_SCRATCH_0, 8'h5a);
        rdchk(ADDR_MESSAGE_SCRATCH_0, 8'h5a, "mbox");
        host_u.wr(ADDR_FRAME_LINES_LOW, 8'hff);
        rdchk(ADDR_FRAME_LINES_LOW, 8'h00, "ro lines");
        host_u.sel(2'h1);
        host_u.wr(ADDR_MESSAGE_SCRATCH_0, 8'ha5);
        host_u.rd(ADDR_MESSAGE_SCRATCH_0, d, ok);
        `CHK("other port answer", 1'b0, ok)
        host_u.sel(2'h0);
        rdchk(ADDR_MESSAGE_SCRATCH_0, 8'h5a, "mbox kept");
    endtask

    // counts above one byte, final line longer than the rest
    task automatic t_measure();
        frame(258, 2, 261);
        rdchk(ADDR_FRAME_LINES_HIGH, 8'h01, "lines hi");
        rdchk(ADDR_FRAME_LINES_LOW, 8'h02, "lines lo");
        rdchk(ADDR_LINE_LENGTH_HIGH, 8'h01, "len hi");
        rdchk(ADDR_LINE_LENGTH_LOW, 8'h05, "len lo");
    endtask

    // with both enables set, an unread value survives a later frame
    task automatic t_freeze();
        ie_lines <= 1'b1;
        ie_len   <= 1'b1;
        frame(5, 7, 7);
        frame(9, 4, 4);
        rdchk(ADDR_FRAME_LINES_HIGH, 8'h00, "frz lines hi");
        rdchk(ADDR_FRAME_LINES_LOW, 8'h05, "frz lines lo");
        rdchk(ADDR_LINE_LENGTH_HIGH, 8'h00, "frz len hi");
        rdchk(ADDR_LINE_LENGTH_LOW, 8'h07, "frz len lo");
        frame(9, 4, 4);
        rdchk(ADDR_FRAME_LINES_LOW, 8'h09, "unfrz lines");
        rdchk(ADDR_LINE_LENGTH_LOW, 8'h04, "unfrz len");
        ie_lines <= 1'b0;
        ie_len   <= 1'b0;
    endtask

    // a new frame between high and low reads must not tear the pair
    task automatic t_latch();
        frame(3, 6, 6);
        rdchk(ADDR_FRAME_LINES_HIGH, 8'h00, "lat lines hi");
        rdchk(ADDR_LINE_LENGTH_HIGH, 8'h00, "lat len hi");
        frame(4, 9, 9);
        rdchk(ADDR_FRAME_LINES_LOW, 8'h03, "lat lines lo");
        rdchk(ADDR_LINE_LENGTH_LOW, 8'h06, "lat len lo");
        rdchk(ADDR_FRAME_LINES_LOW, 8'h04, "live lines lo");
        rdchk(ADDR_LINE_LENGTH_LOW, 8'h09, "live len lo");
    endtask

    // default margin 3 and floor 5, margin boundary exact, floor crossed with 2 and 6
    task automatic t_freq();
        meas(8'h0a);
        `CHK("freq first", 8'h0a, freq_value_mhz_q)
        `CHK("absent off", 1'b0, serial_clock_absent_q)
        meas(8'h0d);
        `CHK("freq in margin", 8'h0a, freq_value_mhz_q)
        meas(8'h0e);
        `CHK("freq past margin", 8'h0e, freq_value_mhz_q)
        meas(8'h02);
        `CHK("absent below", 1'b1, serial_clock_absent_q)
        meas(8'h06);
        `CHK("absent above", 1'b0, serial_clock_absent_q)
    endtask

    // every settle code; each new sample restarts the stability count
    task automatic t_settle();
        int         lim [4] = '{20, 40, 160, 640};
        int         c;
        int         n;
        logic [1:0] cs;
        for (c = 0; c < 4; c++)
        begin
            cs = c[1:0];
            host_u.wr(ADDR_CLOCK_FREQ_MON_CTL, {2'h0, cs, 4'h2});
            rdchk(ADDR_CLOCK_FREQ_MON_CTL, {2'h0, cs, 4'h2}, "ctl");
            meas(8'h20 + {4'h0, cs, 2'h0});
            `CHK("stable early", 1'b0, freq_stable_q)
            n = 3;
            while (freq_stable_q !== 1'b1 && n < lim[c] + 20)
            begin
                @(posedge clk);
                n++;
            end
            `CHK("settle time", 1'b1, (n >= lim[c] && n <= lim[c] + 4))
            if (freq_stable_q !== 1'b1)
                end_sim();
        end
    endtask

    // main sequence
    initial
    begin
        // quiet inputs and reset asserted before the first edge
        sys_rst     <= 1'b1;
        ie_lines    <= 1'b0;
        ie_len      <= 1'b0;
        frame_valid <= 1'b0;
        line_valid  <= 1'b0;
        fm_valid    <= 1'b0;
        fm_mhz      <= 8'h00;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_mailbox();
        t_measure();
        t_freeze();
        t_latch();
        t_freq();
        t_settle();
        end_sim();
    end
endmodule
